// ==== video_fifo_pkg.sv ====
// constants, codes and types shared by the capture data buffer
package video_fifo_pkg;

	// ------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------
	localparam int DATA_W = 32;   // pixel dword width
	localparam int CODE_W = 4;    // status code width
	localparam int WORD_W = 36;   // buffer word: code on top of data
	localparam int CODE_LSB = 32; // code position in the buffer word
	localparam int SEG_N = 3;     // number of segments
	localparam int CNT_W = 8;     // word count / sequence width

	// ------------------------------------------------------------
	// status codes
	// ------------------------------------------------------------
	localparam logic [3:0] PACKED_MODE_MARKER = 4'h6;
	localparam logic [3:0] PLANAR_MODE_MARKER = 4'hE;
	localparam logic [3:0] LINE_FIRST_WORD_CODE = 4'h2;
	localparam logic [3:0] LINE_LAST_WORD_CODE_4 = 4'h1;
	localparam logic [3:0] LINE_LAST_WORD_CODE_3 = 4'hD;
	localparam logic [3:0] LINE_LAST_WORD_CODE_2 = 4'h9;
	localparam logic [3:0] LINE_LAST_WORD_CODE_1 = 4'h5;
	localparam logic [3:0] EVEN_FIELD_END_CODE = 4'h4;
	localparam logic [3:0] ODD_FIELD_END_CODE = 4'hC;
	localparam logic [3:0] PLAIN_VALID_WORD_CODE = 4'h0;

	// ------------------------------------------------------------
	// segment sizes and thresholds
	// ------------------------------------------------------------
	localparam int SEG1_DEPTH = 70;
	localparam int SEG1_FULL = 68;
	localparam int SEG1_AFULL = 64;
	localparam int SEG23_DEPTH = 35;
	localparam int SEG23_FULL = 34;
	localparam int SEG23_AFULL = 32;
	localparam int MERGED_BUFFER_SIZE = 140;
	localparam logic [CNT_W:0] MERGED_FULL = 9'h088;   // 136 words
	localparam logic [CNT_W:0] MERGED_AFULL = 9'h080;  // 128 words

	// ------------------------------------------------------------
	// input queue and writer
	// ------------------------------------------------------------
	localparam int IN_DEPTH = 8;  // staging queue depth
	localparam int ENTRY_W = 40;  // kind, code, plane, data
	localparam logic [1:0] SEG_NONE = 2'h3;  // no segment written last cycle
	localparam logic [1:0] MARK_LAST_STEP = 2'h3;
	localparam logic [1:0] END_LAST_STEP = 2'h2;

	typedef enum logic [1:0] {KIND_PIXEL, KIND_MARKER, KIND_FIELD_END} entry_kind_t;

endpackage : video_fifo_pkg

// ==== stream_fifo.sv ====
// small staging queue with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 40, // entry width
	parameter int DEPTH = 8   // entry count, power of two
) (
	input wire logic clk,                // system clock
	input wire logic nrst,               // async reset, active low
	input wire logic inValid,            // push request
	output logic inReady,                // registered: room and not held
	input wire logic hold,               // forces ready low next cycle
	output logic spaceAvail,             // room for one entry now
	input wire logic [WIDTH-1:0] inData, // pushed entry
	output logic outValid,               // head present
	input wire logic outReady,           // head taken
	output logic [WIDTH-1:0] outData     // head entry
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH]; // entry storage
	logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
	logic [CW-1:0] count, next_count;
	logic next_inReady;
	logic push, pop;

	assign spaceAvail = count != CW'(DEPTH);
	assign outValid = count != '0;
	assign outData = mem[rdPtr];
	assign push = inValid && spaceAvail;
	assign pop = outReady && outValid;

	// ------------------------------------------------------------
	// pointer and count update
	// ------------------------------------------------------------
	always_comb begin
		next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
		next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
		next_count = count + CW'(push) - CW'(pop);
		// ready is registered, so the hold must be known a cycle ahead
		next_inReady = (next_count < CW'(DEPTH)) && !hold;
	end

	// state registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b0;
		end else begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			inReady <= next_inReady;
		end
	end

	// storage has no reset; it is never read before written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

endmodule : stream_fifo
`default_nettype wire

// ==== capture_segment.sv ====
// one buffer segment with gray-coded count path and full flags
`timescale 1ns/1ps
`default_nettype none
module capture_segment #(
	parameter int WIDTH = 36,    // word width
	parameter int DEPTH = 35,    // words held
	parameter int FULL_AT = 34,  // full threshold
	parameter int AFULL_AT = 32  // almost-full threshold
) (
	input wire logic clk,                       // system clock
	input wire logic nrst,                      // async reset, active low
	input wire logic wrEn,                      // write strobe
	input wire logic [WIDTH-1:0] wrWord,        // word to store
	input wire logic rdEn,                      // read and advance
	output logic [WIDTH-1:0] rdWord,            // head word, registered
	output logic rdValid,                       // head present
	output logic [video_fifo_pkg::CNT_W-1:0] count, // words held
	output logic full,                          // count at full threshold
	output logic almostFull                     // count at almost-full threshold
);
	localparam int CW = video_fifo_pkg::CNT_W;
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // word storage
	logic [AW-1:0] wrAddr, rdAddr, next_wrAddr, next_rdAddr;
	logic [CW-1:0] wrSeq, rdSeq, next_wrSeq, next_rdSeq;
	logic [CW-1:0] wrGray, syncA, syncB, next_wrGray; // gray pointer and its synchroniser
	logic [CW-1:0] wrBin, next_count;
	logic rdOk;

	assign rdOk = rdEn && rdValid;

	// ------------------------------------------------------------
	// next pointers, counts and flags
	// ------------------------------------------------------------
	always_comb begin
		next_wrAddr = wrAddr;
		if (wrEn) begin
			next_wrAddr = (wrAddr == AW'(DEPTH - 1)) ? '0 : wrAddr + 1'b1;
		end
		next_wrSeq = wrEn ? wrSeq + 1'b1 : wrSeq;
		next_wrGray = next_wrSeq ^ (next_wrSeq >> 1);
		next_rdAddr = rdAddr;
		if (rdOk) begin
			next_rdAddr = (rdAddr == AW'(DEPTH - 1)) ? '0 : rdAddr + 1'b1;
		end
		next_rdSeq = rdOk ? rdSeq + 1'b1 : rdSeq;
		// decode the synchronised gray pointer back to binary
		wrBin[CW-1] = syncB[CW-1];
		for (int i = CW - 2; i >= 0; i--) begin
			wrBin[i] = wrBin[i+1] ^ syncB[i];
		end
		// lags the writes, so the thresholds sit below capacity
		next_count = wrBin - next_rdSeq;
	end

	// pointer, synchroniser and flag registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrAddr <= '0;
			rdAddr <= '0;
			wrSeq <= '0;
			rdSeq <= '0;
			wrGray <= '0;
			syncA <= '0;
			syncB <= '0;
			count <= '0;
			rdValid <= 1'b0;
			full <= 1'b0;
			almostFull <= 1'b0;
		end else begin
			wrAddr <= next_wrAddr;
			rdAddr <= next_rdAddr;
			wrSeq <= next_wrSeq;
			rdSeq <= next_rdSeq;
			wrGray <= next_wrGray;
			syncA <= wrGray;
			syncB <= syncA;
			count <= next_count;
			rdValid <= next_count != '0;
			full <= next_count >= CW'(FULL_AT);
			almostFull <= next_count >= CW'(AFULL_AT);
		end
	end

	// no overrun guard: a write past capacity overwrites old words
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrWord;
		end
		rdWord <= mem[next_rdAddr];
	end

endmodule : capture_segment
`default_nettype wire

// ==== video_capture_data_fifo.sv ====
// video capture data buffer: status coding, segment steering, three segments
// ------------------------------------------------------------
// Overview of operation
// - word is code over 32-bit pixel dword
// - load only valid pixels in captured field
// - mode marker 0110 packed, 1110 planar
// - line first word 0010, others 0000
// - line last word code gives byte count
// - field end 0100 falling, 1100 rising edge
// - marker at field start, format change, enable
// - markers: two in segment one, one elsewhere
// - line codes ride first and last dwords
// - field end code stored after captured field
// - three segment outputs presented in parallel
// - full when count reaches full threshold
// - segment one: 70 words, 68, 64
// - segments two, three: 35, 34, 32
// - planar independent; packed merges 140 words
// - writes and reads proceed simultaneously
// - never same segment twice in a row
// - one word per segment per cycle
// - packed and planar entries may coexist
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module video_capture_data_fifo (
	input wire logic clk,                   // 200 MHz system clock
	input wire logic nrst,                  // async reset, active low
	input wire logic pixValid,              // pixel dword offered
	output logic pixReady,                  // pixel dword may be taken
	input wire logic [31:0] pixData,        // pixel dword
	input wire logic lineFirst,             // first dword of scan line
	input wire logic lineLast,              // last dword of scan line
	input wire logic [2:0] lastBytes,       // valid bytes of last dword, 1 to 4
	input wire logic [1:0] plane,           // planar target: 0 luma, 1 cb, 2 cr
	input wire logic fieldOdd,              // field indicator
	input wire logic fieldActive,           // active pixel region of field
	input wire logic captureEnable,         // capture of this field enabled
	input wire logic planarMode,            // planar format selected
	input wire logic [2:0] segRead,         // per-segment read strobes
	output logic [2:0][35:0] segWord,       // per-segment head words
	output logic [2:0] segValid,            // per-segment head present
	output logic [2:0][7:0] segmentWordCount, // per-segment word counts
	output logic [2:0] segmentFullFlag,     // per-segment full
	output logic [2:0] segmentAlmostFullFlag, // per-segment almost full
	output logic mergedFull,                // packed total at full
	output logic mergedAlmostFull           // packed total at almost full
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic fieldOddQ, capEnQ, planarQ;        // previous input levels
	logic next_fieldOddQ, next_capEnQ, next_planarQ;
	logic pendEnd, next_pendEnd;             // field end entry waiting
	logic [3:0] pendEndCode, next_pendEndCode;
	logic pendMark, next_pendMark;           // mode marker waiting
	logic fieldEdge, endEvent, markEvent;
	logic pixPush, endPush, markPush;
	logic qPush, qSpace, qValid, qPop;
	logic [video_fifo_pkg::ENTRY_W-1:0] qIn, qOut;
	logic [3:0] pixCode;                     // status code of incoming dword
	video_fifo_pkg::entry_kind_t headKind;
	logic [3:0] headCode;
	logic [1:0] headPlane;
	logic [31:0] headData;
	logic [1:0] step, next_step;             // sub-step of marker or end entry
	logic [1:0] packPos, next_packPos;       // position in packed write order
	logic [1:0] lastSeg, next_lastSeg;       // segment written last cycle
	logic wrPlanar, next_wrPlanar;           // layout set by last marker
	logic [1:0] tgt;                         // segment for this write
	logic lastStep, doWrite;
	logic [2:0] wrEn;
	logic [35:0] wrWord;
	logic [8:0] total;                       // sum of segment counts
	logic next_mergedFull, next_mergedAlmostFull;

	// packed order alternates segment one with the others
	function automatic logic [1:0] packSeg(input logic [1:0] pos);
		unique case (pos)
			2'h0: packSeg = 2'h0;
			2'h1: packSeg = 2'h1;
			2'h2: packSeg = 2'h0;
			2'h3: packSeg = 2'h2;
		endcase
	endfunction : packSeg

	// ------------------------------------------------------------
	// field events and status code of incoming dwords
	// ------------------------------------------------------------
	always_comb begin
		fieldEdge = fieldOdd != fieldOddQ;
		endEvent = fieldEdge && capEnQ;
		// new field, late enable, or format change all restate the mode
		markEvent = (fieldEdge && captureEnable)
			|| (captureEnable && !capEnQ)
			|| (captureEnable && planarMode != planarQ);
		// a one-dword line takes the last code
		pixCode = video_fifo_pkg::PLAIN_VALID_WORD_CODE;
		if (lineLast) begin
			unique case (lastBytes)
				3'h3: pixCode = video_fifo_pkg::LINE_LAST_WORD_CODE_3;
				3'h2: pixCode = video_fifo_pkg::LINE_LAST_WORD_CODE_2;
				3'h1: pixCode = video_fifo_pkg::LINE_LAST_WORD_CODE_1;
				default: pixCode = video_fifo_pkg::LINE_LAST_WORD_CODE_4;
			endcase
		end else if (lineFirst) begin
			pixCode = video_fifo_pkg::LINE_FIRST_WORD_CODE;
		end
	end

	// ------------------------------------------------------------
	// queue entry selection: pending events go ahead of pixels
	// ------------------------------------------------------------
	always_comb begin
		endPush = pendEnd && qSpace;
		markPush = pendMark && !pendEnd && qSpace;
		// pixReady is held low while an event waits, so pixels never collide
		// a dword on the event edge itself is dropped, as it would
		// otherwise land ahead of the entry that the event calls for
		pixPush = pixValid && pixReady && fieldActive && captureEnable
			&& !endEvent && !markEvent;
		// at most one entry enters the queue per cycle
		qPush = endPush || markPush || pixPush;
		if (endPush) begin
			qIn = {video_fifo_pkg::KIND_FIELD_END, pendEndCode, 2'h0, 32'h0000_0000};
		end else if (markPush) begin
			qIn = {video_fifo_pkg::KIND_MARKER, planarMode ? video_fifo_pkg::PLANAR_MODE_MARKER
				: video_fifo_pkg::PACKED_MODE_MARKER, 2'h0, 32'h0000_0000};
		end else begin
			qIn = {video_fifo_pkg::KIND_PIXEL, pixCode, plane, pixData};
		end
		// an event arriving as its entry is pushed is kept
		next_pendEnd = (pendEnd && !endPush) || endEvent;
		next_pendEndCode = pendEndCode;
		// the code names the field that now begins
		if (endEvent) begin
			next_pendEndCode = fieldOddQ ? video_fifo_pkg::EVEN_FIELD_END_CODE
				: video_fifo_pkg::ODD_FIELD_END_CODE;
		end
		next_pendMark = (pendMark && !markPush) || markEvent;
		// previous levels feed the edge detectors
		next_fieldOddQ = fieldOdd;
		next_capEnQ = captureEnable;
		next_planarQ = planarMode;
	end

	// event registers
	// levels reset to the idle state of the inputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fieldOddQ <= 1'b0;
			capEnQ <= 1'b0;
			planarQ <= 1'b0;
			pendEnd <= 1'b0;
			pendEndCode <= video_fifo_pkg::EVEN_FIELD_END_CODE;
			pendMark <= 1'b0;
		end else begin
			fieldOddQ <= next_fieldOddQ;
			capEnQ <= next_capEnQ;
			planarQ <= next_planarQ;
			pendEnd <= next_pendEnd;
			pendEndCode <= next_pendEndCode;
			pendMark <= next_pendMark;
		end
	end

	// ------------------------------------------------------------
	// staging queue between the converter and the segment writer
	// ------------------------------------------------------------
	// hold drops ready a cycle ahead of any event entry
	stream_fifo #(
		.WIDTH(video_fifo_pkg::ENTRY_W),
		.DEPTH(video_fifo_pkg::IN_DEPTH)
	) stage (
		.clk(clk),
		.nrst(nrst),
		.inValid(qPush),
		.inReady(pixReady),
		.hold(next_pendEnd || next_pendMark),
		.spaceAvail(qSpace),
		.inData(qIn),
		.outValid(qValid),
		.outReady(qPop),
		.outData(qOut)
	);

	// ------------------------------------------------------------
	// segment writer: steers head entry, one write per cycle
	// ------------------------------------------------------------
	always_comb begin
		// unpack the head entry
		headKind = video_fifo_pkg::entry_kind_t'(qOut[39:38]);
		headCode = qOut[37:34];
		headPlane = qOut[33:32];
		headData = qOut[31:0];
		tgt = video_fifo_pkg::SEG_NONE;
		lastStep = 1'b0;
		// events take several writes, pixels one
		unique case (headKind)
			video_fifo_pkg::KIND_MARKER: begin
				tgt = packSeg(step);
				lastStep = step == video_fifo_pkg::MARK_LAST_STEP;
			end
			video_fifo_pkg::KIND_FIELD_END: begin
				tgt = step;
				lastStep = step == video_fifo_pkg::END_LAST_STEP;
			end
			default: begin
				// planar feeds planes apart, packed spreads over all segments
				tgt = wrPlanar ? ((headPlane == 2'h3) ? 2'h0 : headPlane) : packSeg(packPos);
				lastStep = 1'b1;
			end
		endcase
		// a repeat of last cycle's segment waits one bubble
		doWrite = qValid && tgt != lastSeg;
		qPop = doWrite && lastStep;
		// event words carry no pixel data
		wrWord = {headCode, (headKind == video_fifo_pkg::KIND_PIXEL) ? headData : 32'h0000_0000};
		wrEn = doWrite ? (3'h1 << tgt) : 3'h0;
		next_lastSeg = doWrite ? tgt : video_fifo_pkg::SEG_NONE;
		// sub-step restarts once the head entry is done
		next_step = qPop ? 2'h0 : (doWrite ? step + 1'b1 : step);
		next_packPos = packPos;
		next_wrPlanar = wrPlanar;
		if (qPop && headKind == video_fifo_pkg::KIND_MARKER) begin
			next_packPos = 2'h0;
			// marker switches layout; older entries keep theirs
			next_wrPlanar = headCode == video_fifo_pkg::PLANAR_MODE_MARKER;
		end else if (doWrite && headKind == video_fifo_pkg::KIND_PIXEL && !wrPlanar) begin
			next_packPos = packPos + 1'b1;
		end
	end

	// writer registers
	// packed layout until the first marker arrives
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			step <= 2'h0;
			packPos <= 2'h0;
			lastSeg <= video_fifo_pkg::SEG_NONE;
			wrPlanar <= 1'b0;
		end else begin
			step <= next_step;
			packPos <= next_packPos;
			lastSeg <= next_lastSeg;
			wrPlanar <= next_wrPlanar;
		end
	end

	// ------------------------------------------------------------
	// three segments, read in parallel while being written
	// ------------------------------------------------------------
	// segment one is twice as deep as the others
	for (genvar g = 0; g < video_fifo_pkg::SEG_N; g++) begin : gSeg
		capture_segment #(
			.WIDTH(video_fifo_pkg::WORD_W),
			.DEPTH(g == 0 ? video_fifo_pkg::SEG1_DEPTH : video_fifo_pkg::SEG23_DEPTH),
			.FULL_AT(g == 0 ? video_fifo_pkg::SEG1_FULL : video_fifo_pkg::SEG23_FULL),
			.AFULL_AT(g == 0 ? video_fifo_pkg::SEG1_AFULL : video_fifo_pkg::SEG23_AFULL)
		) seg (
			.clk(clk),
			.nrst(nrst),
			.wrEn(wrEn[g]),
			.wrWord(wrWord),
			.rdEn(segRead[g]),
			.rdWord(segWord[g]),
			.rdValid(segValid[g]),
			.count(segmentWordCount[g]),
			.full(segmentFullFlag[g]),
			.almostFull(segmentAlmostFullFlag[g])
		);
	end

	// ------------------------------------------------------------
	// merged flags for packed use of all three segments
	// ------------------------------------------------------------
	always_comb begin
		// registered counts add one cycle of lag
		total = 9'(segmentWordCount[0]) + 9'(segmentWordCount[1]) + 9'(segmentWordCount[2]);
		next_mergedFull = total >= video_fifo_pkg::MERGED_FULL;
		next_mergedAlmostFull = total >= video_fifo_pkg::MERGED_AFULL;
	end

	// merged flag registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mergedFull <= 1'b0;
			mergedAlmostFull <= 1'b0;
		end else begin
			mergedFull <= next_mergedFull;
			mergedAlmostFull <= next_mergedAlmostFull;
		end
	end

endmodule : video_capture_data_fifo
`default_nettype wire

// ==== video_capture_data_fifo_sva.sv ====
// port assertions for the capture data buffer
`timescale 1ns/1ps
`default_nettype none
module video_capture_data_fifo_sva (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire logic pixReady, // input ready
	input wire logic fieldOdd, // field level
	input wire logic captureEnable, // capture on
	input wire logic [2:0] segRead, // reads
	input wire logic [2:0][35:0] segWord, // heads
	input wire logic [2:0] segValid, // head present
	input wire logic [2:0][7:0] segmentWordCount, // counts
	input wire logic [2:0] segmentFullFlag, // full
	input wire logic [2:0] segmentAlmostFullFlag, // near full
	input wire logic mergedFull, // merged full
	input wire logic mergedAlmostFull // merged near full
);
	// --------
	// helpers
	// --------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [9:0] total; // merged count
	assign total = 10'(segmentWordCount[0]) + 10'(segmentWordCount[1])
		+ 10'(segmentWordCount[2]);
	sequence s_field_edge;
		$changed(fieldOdd) && $past(captureEnable);
	endsequence
	// ready may drop up to three edges late: edge is registered first
	sequence s_ready_gap;
		##[0:3] !pixReady;
	endsequence
	// --------
	// properties
	// --------
	property p_full;
		segmentFullFlag == {segmentWordCount[2] >= 8'h22,
			segmentWordCount[1] >= 8'h22, segmentWordCount[0] >= 8'h44};
	endproperty
	property p_afull;
		segmentAlmostFullFlag == {segmentWordCount[2] >= 8'h20,
			segmentWordCount[1] >= 8'h20, segmentWordCount[0] >= 8'h40};
	endproperty
	property p_mfull;
		mergedFull == ($past(total) >= 10'h088);
	endproperty
	property p_mafull;
		mergedAlmostFull == ($past(total) >= 10'h080);
	endproperty
	property p_code;
		segValid[0] |-> segWord[0][35:32] inside {4'h6, 4'hE, 4'h2, 4'h1,
			4'hD, 4'h9, 4'h5, 4'h4, 4'hC, 4'h0};
	endproperty
	property p_hold;
		segValid[1] && !segRead[1] |=> segValid[1] && $stable(segWord[1]);
	endproperty
	property p_field_gap;
		s_field_edge |-> s_ready_gap;
	endproperty
	property p_enable_gap;
		$rose(captureEnable) |-> s_ready_gap;
	endproperty
	property p_cap;
		segmentWordCount[0] <= 8'h46 && segmentWordCount[2] <= 8'h23;
	endproperty
	a_full: assert property (p_full)
		else $error("full flag wrong");
	a_afull: assert property (p_afull)
		else $error("almost full flag wrong");
	a_mfull: assert property (p_mfull)
		else $error("merged full wrong");
	a_mafull: assert property (p_mafull)
		else $error("merged almost full wrong");
	a_code: assert property (p_code)
		else $error("illegal status code");
	a_hold: assert property (p_hold)
		else $error("head word moved unread");
	a_field_gap: assert property (p_field_gap)
		else $error("no pause at field edge");
	a_enable_gap: assert property (p_enable_gap)
		else $error("no pause at enable");
	a_cap: assert property (p_cap)
		else $error("count beyond size");
endmodule : video_capture_data_fifo_sva
bind video_capture_data_fifo video_capture_data_fifo_sva u_sva (.clk, .nrst,
	.pixReady, .fieldOdd, .captureEnable, .segRead, .segWord, .segValid,
	.segmentWordCount, .segmentFullFlag, .segmentAlmostFullFlag, .mergedFull,
	.mergedAlmostFull);
`default_nettype wire

// ==== buffer_reader_model.sv ====
// reader partner: drains the three segment heads
`timescale 1ns/1ps
`default_nettype none
module buffer_reader_model (
	input wire logic clk, // clock
	input wire logic nrst, // reset, low
	input wire logic [2:0] stall, // bench hold-off
	input wire logic [2:0] segValid, // head present
	input wire logic [2:0] nearFull, // almost full
	output logic [2:0] segRead // reads
);
	logic [2:0] held; // stall taken at the edge
	// register stall so reads change just after the edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			held <= 3'h7;
		else
			held <= stall;
	end
	// near full beats stall: the writer has no overrun guard
	// every head word is taken, sorting is the bench's job
	assign segRead = segValid & (~held | nearFull);
endmodule : buffer_reader_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the capture data buffer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, nrst = 1'b0, pixValid = 1'b0, pixReady; // core
	logic [31:0] pixData = 32'h0; // pixel dword
	logic lineFirst = 1'b0, lineLast = 1'b0, fieldOdd = 1'b0; // framing
	logic fieldActive = 1'b1, captureEnable = 1'b0, planarMode = 1'b0;
	logic [2:0] lastBytes = 3'h4, segRead, segValid, stall = 3'h0; // misc
	logic [1:0] plane = 2'h0, tgt; // planar target
	logic [2:0][35:0] segWord; // heads
	logic [2:0][7:0] cnt; // counts
	logic [2:0] fullF, afullF; // flags
	logic mFull, mAfull; // merged flags
	logic [35:0] expQ [3][$]; // expected words per segment
	logic pOdd = 1'b0, pCap = 1'b0, pPl = 1'b0, layPl = 1'b0, ev, mk; // history
	int step = 0, mode = 0, failures = 0, checked = 0, cycles = 0, seedv;
	always #2.5 clk = ~clk;
	video_capture_data_fifo u_dut (.clk, .nrst, .pixValid, .pixReady,
		.pixData, .lineFirst, .lineLast, .lastBytes, .plane, .fieldOdd,
		.fieldActive, .captureEnable, .planarMode, .segRead, .segWord,
		.segValid, .segmentWordCount(cnt), .segmentFullFlag(fullF),
		.segmentAlmostFullFlag(afullF), .mergedFull(mFull),
		.mergedAlmostFull(mAfull));
	buffer_reader_model u_reader (.clk, .nrst, .stall, .segValid,
		.nearFull(afullF), .segRead);
	// --------
	// expectation helpers
	// --------
	function automatic logic [1:0] pk(input int s);
		return (s == 1) ? 2'h1 : (s == 3) ? 2'h2 : 2'h0;
	endfunction : pk
	function automatic logic [3:0] code_of(input logic f, input logic l,
		input logic [2:0] b);
		if (l)
			return (b == 3'h1) ? 4'h5 : (b == 3'h2) ? 4'h9 : (b == 3'h3) ? 4'hD : 4'h1;
		return f ? 4'h2 : 4'h0;
	endfunction : code_of
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	// --------
	// monitor: predict entries, compare every read
	// --------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
		ev = nrst && fieldOdd != pOdd && pCap;
		mk = nrst && captureEnable && (fieldOdd != pOdd || !pCap || planarMode != pPl);
		if (ev)
			for (int k = 0; k < 3; k++) expQ[k].push_back({fieldOdd ? 4'hC : 4'h4, 32'h0});
		if (mk) begin
			for (int k = 0; k < 4; k++) expQ[pk(k)].push_back({planarMode ? 4'hE : 4'h6, 32'h0});
			layPl = planarMode;
			step = 0;
		end
		// pixels outside the active captured field are dropped
		if (nrst && pixValid && pixReady && fieldActive && captureEnable
			&& !ev && !mk) begin
			tgt = layPl ? ((plane == 2'h3) ? 2'h0 : plane) : pk(step);
			expQ[tgt].push_back({code_of(lineFirst, lineLast, lastBytes), pixData});
			step = (step + 1) % 4;
		end
		for (int k = 0; k < 3; k++)
			if (segRead[k] && segValid[k])
				chk(segWord[k], expQ[k].size() ? expQ[k].pop_front() : 36'hF00000000);
		pOdd = fieldOdd;
		pCap = captureEnable;
		pPl = planarMode;
	end
	// reader pace: prompt, random, or held until near full
	always @(negedge clk)
		stall = (mode == 0) ? 3'h0 : (mode == 1) ? 3'($urandom) : 3'h7;
	// --------
	// drivers
	// --------
	task automatic idle(input int n);
		@(negedge clk);
		pixValid = 1'b0;
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic send_line(input int len);
		int w;
		for (int i = 0; i < len; i++) begin
			@(negedge clk);
			pixValid = 1'b1;
			pixData = $urandom;
			lineFirst = (i == 0);
			lineLast = (i == len - 1);
			lastBytes = 3'($urandom_range(1, 4));
			plane = 2'($urandom_range(0, 3));
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (pixReady !== 1'b1 && w < 50);
		end
	endtask : send_line
	// --------
	// main sequence
	// --------
	initial begin
		seedv = $urandom(75);
		repeat (3) @(negedge clk);
		chk(36'({segValid, fullF, afullF, mFull, mAfull, pixReady}), 36'h0);
		nrst = 1'b1;
		idle(2);
		captureEnable = 1'b1;
		for (int f = 0; f < 6; f++) begin
			idle(4);
			mode = f % 3;
			for (int l = 0; l < 4; l++) send_line($urandom_range(1, 9));
			idle(2);
			if (f % 2 == 0)
				planarMode = ~planarMode;
			else
				fieldOdd = ~fieldOdd;
		end
		idle(4);
		planarMode = 1'b0;
		mode = 2;
		send_line(70);
		send_line(70);
		idle(2);
		fieldActive = 1'b0;
		send_line(5);
		idle(2);
		fieldActive = 1'b1;
		captureEnable = 1'b0;
		send_line(5);
		idle(2);
		fieldOdd = ~fieldOdd;
		idle(4);
		captureEnable = 1'b1;
		idle(4);
		send_line(6);
		idle(2);
		mode = 0;
		idle(80);
		chk(36'(expQ[0].size() + expQ[1].size() + expQ[2].size()), 36'h0);
		chk(36'({cnt, segValid}), 36'h0);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
